// ==== hw/gdr_pkg.sv ====
// Constants for the gate delay reduction configuration bank.
// Assumes a 250 MHz system clock and a slow serial register port.
package gdr_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam int          NUM_BRIDGES       = 4;
   localparam int          NUM_REGS          = 5;
   localparam logic [6:0]  ADDR_BRIDGE1_LIMIT = 7'h2b;
   localparam logic [6:0]  ADDR_BRIDGE2_LIMIT = 7'h2c;
   localparam logic [6:0]  ADDR_BRIDGE3_LIMIT = 7'h2d;
   localparam logic [6:0]  ADDR_BRIDGE4_LIMIT = 7'h2e;
   localparam logic [6:0]  ADDR_BRIDGE1_PRE   = 7'h2f;
   localparam int          IDX_BRIDGE1_PRE    = 4;
   localparam logic [7:0]  RESET_LIMIT        = 8'h0a;
   localparam logic [7:0]  RESET_PRE          = 8'hf6;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int MAX_CUR_LSB   = 6;
   localparam int DELAY_LSB     = 0;
   localparam int DELAY_W       = 6;
   localparam int PRE_CHR_LSB   = 6;
   localparam int PRE_DCHR_LSB  = 4;
   localparam int INIT_CHR_LSB  = 2;
   localparam int INIT_DCHR_LSB = 0;

   // ************************************************************
   // Serial frame: R/W bit, 7-bit address, 8-bit data, MSB first
   // ************************************************************
   localparam logic [4:0] FRAME_BITS = 5'h10;
   localparam logic [4:0] HEAD_BITS  = 5'h08;
   localparam int         RW_BIT     = 15;

   // ************************************************************
   // Timing and scaling
   // ************************************************************
   localparam int          DELAY_STEP_NS     = 140;
   localparam int          CLK_PERIOD_NS     = 4;
   localparam int          DELAY_STEP_CYCLES = DELAY_STEP_NS / CLK_PERIOD_NS;
   localparam int          CYC_W             = 12;
   localparam int          RATIO_SHIFT       = 3;
   localparam logic [6:0]  MAX_CUR_BASE_MA   = 7'h40;
   localparam logic [5:0]  INIT_CUR_BASE_MA  = 6'h04;
   localparam logic [CYC_W-1:0] RESET_DELAY_CYCLES =
      CYC_W'(10 * DELAY_STEP_CYCLES);
   localparam logic [CYC_W-1:0] RESET_PRE_CYCLES   =
      CYC_W'((10 * DELAY_STEP_CYCLES * 4) >> RATIO_SHIFT);
   localparam logic [5:0]  RESET_INIT_CHR_MA  = 6'h08;
   localparam logic [5:0]  RESET_INIT_DCHR_MA = 6'h10;

endpackage : gdr_pkg

// ==== hw/gdr_pin_sync.sv ====
// Three-stage synchroniser with agreement filter for pin inputs.
// Assumes pins change slowly against the system clock.
module gdr_pin_sync #(
   parameter int               WIDTH     = 3,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst,
   // Pins in, filtered levels out
   input  wire logic [WIDTH-1:0] pin,
   output      logic [WIDTH-1:0] level
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
      logic [WIDTH-1:0] s3;
      logic [WIDTH-1:0] out;
   } gdr_sync_t;

   gdr_sync_t s;
   gdr_sync_t next_s;

   // Refuse a width that leaves no pin to synchronise
   if (WIDTH < 1) begin : g_bad_width
      $error("gdr_pin_sync: WIDTH must be at least 1");
   end

   // Second and third stages must agree before the level moves
   always_comb begin
      next_s     = s;
      next_s.s1  = pin;
      next_s.s2  = s.s1;
      next_s.s3  = s.s2;
      for (int i = 0; i < WIDTH; i++) begin
         if (s.s2[i] == s.s3[i]) begin
            next_s.out[i] = s.s3[i];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s <= '{s1: RESET_VAL, s2: RESET_VAL, s3: RESET_VAL, out: RESET_VAL};
      end else begin
         s <= next_s;
      end
   end

   assign level = s.out;

endmodule : gdr_pin_sync

// ==== hw/gdr_config_bank.sv ====
// Configuration bank for the delay reduction loop of four half-bridges.
// Reached over a serial register port (chip select, clock, data in/out);
// the serial clock must be far slower than CLK_SYS.
module gdr_config_bank (
   // Clock and reset
   input  wire logic                                     CLK_SYS,
   input  wire logic                                     RST,
   // Serial register port pins
   input  wire logic                                     SCS_N,
   input  wire logic                                     SCLK,
   input  wire logic                                     SDI,
   output      logic                                     SDO,
   output      logic                                     SDO_OE,
   // Per-bridge settings
   output      logic [gdr_pkg::NUM_BRIDGES-1:0][1:0]     MAX_CURRENT_SEL,
   output      logic [gdr_pkg::NUM_BRIDGES-1:0][6:0]     MAX_CURRENT_MA,
   output      logic [gdr_pkg::NUM_BRIDGES-1:0][5:0]     ON_OFF_DELAY_TARGET,
   output      logic [gdr_pkg::NUM_BRIDGES-1:0][11:0]    ON_OFF_DELAY_CYCLES,
   // Bridge 1 pre-charge settings
   output      logic [1:0]                               PRE_CHARGE_TIME_RATIO,
   output      logic [1:0]                               PRE_DISCHARGE_TIME_RATIO,
   output      logic [11:0]                              PRE_CHARGE_CYCLES,
   output      logic [11:0]                              PRE_DISCHARGE_CYCLES,
   output      logic [1:0]                               INITIAL_PRE_CHARGE_CURRENT,
   output      logic [1:0]                               INITIAL_PRE_DISCHARGE_CURRENT,
   output      logic [5:0]                               INITIAL_PRE_CHARGE_MA,
   output      logic [5:0]                               INITIAL_PRE_DISCHARGE_MA
);

   import gdr_pkg::*;

   // ************************************************************
   // State
   // ************************************************************
   typedef struct packed {
      logic                               sclk_q;
      logic                               scs_n_q;
      logic [15:0]                        shift;
      logic [4:0]                         count;
      logic [7:0]                         rdata;
      logic                               sdo;
      logic                               sdo_oe;
      logic [NUM_REGS-1:0][7:0]           regs;
      logic [NUM_BRIDGES-1:0][6:0]        max_ma;
      logic [NUM_BRIDGES-1:0][CYC_W-1:0]  delay_cyc;
      logic [CYC_W-1:0]                   pre_chr_cyc;
      logic [CYC_W-1:0]                   pre_dchr_cyc;
      logic [5:0]                         init_chr_ma;
      logic [5:0]                         init_dchr_ma;
   } gdr_state_t;

   localparam gdr_state_t RESET_STATE = '{
      sclk_q:       1'b0,
      scs_n_q:      1'b1,
      shift:        '0,
      count:        '0,
      rdata:        '0,
      sdo:          1'b0,
      sdo_oe:       1'b0,
      regs:         {RESET_PRE, {NUM_BRIDGES{RESET_LIMIT}}},
      max_ma:       {NUM_BRIDGES{MAX_CUR_BASE_MA}},
      delay_cyc:    {NUM_BRIDGES{RESET_DELAY_CYCLES}},
      pre_chr_cyc:  RESET_PRE_CYCLES,
      pre_dchr_cyc: RESET_PRE_CYCLES,
      init_chr_ma:  RESET_INIT_CHR_MA,
      init_dchr_ma: RESET_INIT_DCHR_MA
   };

   gdr_state_t s;
   gdr_state_t next_s;

   logic scs_n_s;
   logic sclk_s;
   logic sdi_s;

   // Refuse a register map that the decode cannot serve
   if (NUM_REGS != NUM_BRIDGES + 1) begin : g_bad_map
      $error("gdr_config_bank: register count mismatch");
   end

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   gdr_pin_sync #(
      .WIDTH     (3),
      .RESET_VAL (3'h4)
   ) u_sync (
      .clk   (CLK_SYS),
      .rst   (RST),
      .pin   ({SCS_N, SCLK, SDI}),
      .level ({scs_n_s, sclk_s, sdi_s})
   );

   // ************************************************************
   // Address decode and read mux
   // ************************************************************
   function automatic logic hit(input logic [6:0] addr);
      hit = (addr >= ADDR_BRIDGE1_LIMIT) && (addr <= ADDR_BRIDGE1_PRE);
   endfunction : hit

   function automatic logic [2:0] index(input logic [6:0] addr);
      logic [6:0] off;
      off   = addr - ADDR_BRIDGE1_LIMIT;
      index = off[2:0];
   endfunction : index

   // ************************************************************
   // Next state
   // ************************************************************
   always_comb begin
      logic             sclk_rise;
      logic             sclk_fall;
      logic [7:0]       rd;
      logic [6:0]       waddr;
      logic [CYC_W-1:0] dcyc;
      logic [1:0]       code;
      logic [14:0]      prod;
      sclk_rise = 1'b0;
      sclk_fall = 1'b0;
      rd        = '0;
      waddr     = '0;
      dcyc      = '0;
      code      = '0;
      prod      = '0;
      next_s    = s;

      sclk_rise      = sclk_s & ~s.sclk_q;
      sclk_fall      = ~sclk_s & s.sclk_q;
      next_s.sclk_q  = sclk_s;
      next_s.scs_n_q = scs_n_s;

      if (scs_n_s) begin
         next_s.count  = '0;
         next_s.sdo    = 1'b0;
         next_s.sdo_oe = 1'b0;
         // Commit a complete write frame as chip select rises
         waddr = s.shift[RW_BIT-1 -: 7];
         if (!s.scs_n_q && (s.count == FRAME_BITS) && !s.shift[RW_BIT] && hit(waddr)) begin
            next_s.regs[index(waddr)] = s.shift[7:0];
         end
      end else begin
         next_s.sdo_oe = 1'b1;
         if (sclk_rise && (s.count < FRAME_BITS)) begin
            next_s.shift = {s.shift[14:0], sdi_s};
            next_s.count = s.count + 5'h01;
         end
         if (sclk_fall && (s.count >= HEAD_BITS) && (s.count < FRAME_BITS)) begin
            rd = s.rdata;
            if (s.count == HEAD_BITS) begin
               // Unlisted offsets read as zero
               rd = hit(s.shift[6:0]) ? s.regs[index(s.shift[6:0])] : 8'h00;
            end
            next_s.sdo   = rd[7];
            next_s.rdata = {rd[6:0], 1'b0};
         end
      end

      // Decoded settings follow the registers one cycle later
      for (int b = 0; b < NUM_BRIDGES; b++) begin
         code = s.regs[b][MAX_CUR_LSB +: 2];
         next_s.max_ma[b] = MAX_CUR_BASE_MA >> code;
         next_s.delay_cyc[b] = CYC_W'(s.regs[b][DELAY_LSB +: DELAY_W])
                               * CYC_W'(DELAY_STEP_CYCLES);
      end
      dcyc = next_s.delay_cyc[0];

      code = s.regs[IDX_BRIDGE1_PRE][PRE_CHR_LSB +: 2];
      prod = 15'(dcyc) * 15'({1'b0, code} + 3'h1);
      next_s.pre_chr_cyc = prod[RATIO_SHIFT +: CYC_W];

      code = s.regs[IDX_BRIDGE1_PRE][PRE_DCHR_LSB +: 2];
      prod = 15'(dcyc) * 15'({1'b0, code} + 3'h1);
      next_s.pre_dchr_cyc = prod[RATIO_SHIFT +: CYC_W];

      code = s.regs[IDX_BRIDGE1_PRE][INIT_CHR_LSB +: 2];
      next_s.init_chr_ma = INIT_CUR_BASE_MA << code;

      code = s.regs[IDX_BRIDGE1_PRE][INIT_DCHR_LSB +: 2];
      next_s.init_dchr_ma = INIT_CUR_BASE_MA << code;
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         s <= RESET_STATE;
      end else begin
         s <= next_s;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   always_comb begin
      for (int b = 0; b < NUM_BRIDGES; b++) begin
         MAX_CURRENT_SEL[b]     = s.regs[b][MAX_CUR_LSB +: 2];
         ON_OFF_DELAY_TARGET[b] = s.regs[b][DELAY_LSB +: DELAY_W];
      end
   end

   assign SDO                           = s.sdo;
   assign SDO_OE                        = s.sdo_oe;
   assign MAX_CURRENT_MA                = s.max_ma;
   assign ON_OFF_DELAY_CYCLES           = s.delay_cyc;
   assign PRE_CHARGE_TIME_RATIO         = s.regs[IDX_BRIDGE1_PRE][PRE_CHR_LSB +: 2];
   assign PRE_DISCHARGE_TIME_RATIO      = s.regs[IDX_BRIDGE1_PRE][PRE_DCHR_LSB +: 2];
   assign PRE_CHARGE_CYCLES             = s.pre_chr_cyc;
   assign PRE_DISCHARGE_CYCLES          = s.pre_dchr_cyc;
   assign INITIAL_PRE_CHARGE_CURRENT    = s.regs[IDX_BRIDGE1_PRE][INIT_CHR_LSB +: 2];
   assign INITIAL_PRE_DISCHARGE_CURRENT = s.regs[IDX_BRIDGE1_PRE][INIT_DCHR_LSB +: 2];
   assign INITIAL_PRE_CHARGE_MA         = s.init_chr_ma;
   assign INITIAL_PRE_DISCHARGE_MA      = s.init_dchr_ma;

endmodule : gdr_config_bank

// ==== sim/gdr_config_bank_properties.sv ====
// Port assertions for the delay reduction configuration bank.
// Assumes binding to every gdr_config_bank, one clock domain.
module gdr_config_bank_properties (
   // Time base of the bench
   // Clock and reset
   input wire logic             CLK_SYS,
   input wire logic             RST,
   // Serial port
   input wire logic             SCS_N,
   input wire logic             SDO_OE,
   // Settings
   input wire logic [3:0][1:0]  MAX_CURRENT_SEL,
   input wire logic [3:0][6:0]  MAX_CURRENT_MA,
   input wire logic [3:0][5:0]  ON_OFF_DELAY_TARGET,
   input wire logic [3:0][11:0] ON_OFF_DELAY_CYCLES,
   input wire logic [1:0]       PRE_CHARGE_TIME_RATIO,
   input wire logic [1:0]       PRE_DISCHARGE_TIME_RATIO,
   input wire logic [11:0]      PRE_CHARGE_CYCLES,
   input wire logic [11:0]      PRE_DISCHARGE_CYCLES,
   input wire logic [1:0]       INITIAL_PRE_CHARGE_CURRENT,
   input wire logic [1:0]       INITIAL_PRE_DISCHARGE_CURRENT,
   input wire logic [5:0]       INITIAL_PRE_CHARGE_MA,
   input wire logic [5:0]       INITIAL_PRE_DISCHARGE_MA
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RST);

   AST_RST_LIMIT: assert property ($fell(RST) |-> ON_OFF_DELAY_TARGET == {4{6'h0a}})
      else $error("bridge fields not at reset value");
   AST_RST_PRE: assert property (
      $fell(RST) |-> {PRE_CHARGE_TIME_RATIO, PRE_DISCHARGE_TIME_RATIO,
      INITIAL_PRE_CHARGE_CURRENT, INITIAL_PRE_DISCHARGE_CURRENT} == 8'hf6)
      else $error("bridge 1 pre fields not at reset value");
   for (genvar b = 0; b < 4; b++) begin : g_br
      AST_MAX_MA: assert property (MAX_CURRENT_MA[b] == 7'(64 >> $past(MAX_CURRENT_SEL[b])))
         else $error("max current mA wrong");
      AST_DLY_CYC: assert property (ON_OFF_DELAY_CYCLES[b] == 12'(35 * $past(ON_OFF_DELAY_TARGET[b])))
         else $error("delay cycles wrong");
   end
   // Pre times follow the register one cycle later, like the delay cycles
   AST_PRE_CYC: assert property (
      PRE_CHARGE_CYCLES == 12'((35 * $past(ON_OFF_DELAY_TARGET[0])
      * ($past(PRE_CHARGE_TIME_RATIO) + 1)) >> 3))
      else $error("pre charge cycles wrong");
   AST_PRE_DCYC: assert property (
      PRE_DISCHARGE_CYCLES == 12'((35 * $past(ON_OFF_DELAY_TARGET[0])
      * ($past(PRE_DISCHARGE_TIME_RATIO) + 1)) >> 3))
      else $error("pre discharge cycles wrong");
   AST_INIT_CHR: assert property (INITIAL_PRE_CHARGE_MA == 6'(4 << $past(INITIAL_PRE_CHARGE_CURRENT)))
      else $error("initial charge mA wrong");
   AST_INIT_DCHR: assert property (INITIAL_PRE_DISCHARGE_MA == 6'(4 << $past(INITIAL_PRE_DISCHARGE_CURRENT)))
      else $error("initial discharge mA wrong");
   AST_HOLD: assert property (!SCS_N ##1 !SCS_N |-> $stable({MAX_CURRENT_SEL, ON_OFF_DELAY_TARGET}))
      else $error("settings changed inside a frame");
   AST_OE_ON: assert property (!SCS_N [*8] |-> SDO_OE)
      else $error("data out not enabled while selected");
   AST_OE_OFF: assert property (SCS_N [*8] |-> !SDO_OE)
      else $error("data out enabled while deselected");
endmodule : gdr_config_bank_properties

bind gdr_config_bank gdr_config_bank_properties i_gdr_config_bank_properties (
   .CLK_SYS(CLK_SYS), .RST(RST), .SCS_N(SCS_N), .SDO_OE(SDO_OE),
   .MAX_CURRENT_SEL(MAX_CURRENT_SEL), .MAX_CURRENT_MA(MAX_CURRENT_MA),
   .ON_OFF_DELAY_TARGET(ON_OFF_DELAY_TARGET), .ON_OFF_DELAY_CYCLES(ON_OFF_DELAY_CYCLES),
   .PRE_CHARGE_TIME_RATIO(PRE_CHARGE_TIME_RATIO), .PRE_DISCHARGE_TIME_RATIO(PRE_DISCHARGE_TIME_RATIO),
   .PRE_CHARGE_CYCLES(PRE_CHARGE_CYCLES), .PRE_DISCHARGE_CYCLES(PRE_DISCHARGE_CYCLES),
   .INITIAL_PRE_CHARGE_CURRENT(INITIAL_PRE_CHARGE_CURRENT),
   .INITIAL_PRE_DISCHARGE_CURRENT(INITIAL_PRE_DISCHARGE_CURRENT),
   .INITIAL_PRE_CHARGE_MA(INITIAL_PRE_CHARGE_MA), .INITIAL_PRE_DISCHARGE_MA(INITIAL_PRE_DISCHARGE_MA));

// ==== sim/tb_gdr_config_bank.sv ====
// Self-checking bench for the delay reduction configuration bank.
// Drives the serial register port itself; no partner model.
module tb_gdr_config_bank;
   timeunit 1ns;
   timeprecision 100ps;
   import gdr_pkg::*;

   logic clk_sys, rst, scs_n, sclk, sdi, sdo, sdo_oe;
   logic [3:0][1:0]  max_sel;
   logic [3:0][6:0]  max_ma;
   logic [3:0][5:0]  dly;
   logic [3:0][11:0] dly_cyc;
   logic [1:0]       chr_r, dchr_r, chr_i, dchr_i;
   logic [11:0]      chr_cyc, dchr_cyc;
   logic [5:0]       chr_ma, dchr_ma;
   int               fail_count = 0;
   int               n_tests = 0;

   gdr_config_bank i_gdr_config_bank (
      .CLK_SYS(clk_sys), .RST(rst), .SCS_N(scs_n), .SCLK(sclk), .SDI(sdi), .SDO(sdo),
      .SDO_OE(sdo_oe), .MAX_CURRENT_SEL(max_sel), .MAX_CURRENT_MA(max_ma),
      .ON_OFF_DELAY_TARGET(dly), .ON_OFF_DELAY_CYCLES(dly_cyc),
      .PRE_CHARGE_TIME_RATIO(chr_r), .PRE_DISCHARGE_TIME_RATIO(dchr_r),
      .PRE_CHARGE_CYCLES(chr_cyc), .PRE_DISCHARGE_CYCLES(dchr_cyc),
      .INITIAL_PRE_CHARGE_CURRENT(chr_i), .INITIAL_PRE_DISCHARGE_CURRENT(dchr_i),
      .INITIAL_PRE_CHARGE_MA(chr_ma), .INITIAL_PRE_DISCHARGE_MA(dchr_ma));

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   // ************************************************************
   // Helpers
   // ************************************************************
   task cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : cyc

   task chk_out(input logic [11:0] got, input logic [11:0] exp, input string msg);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask : chk_out

   task chk_reg(input logic [7:0] got, input logic [7:0] exp);
      chk_out({4'h0, got}, {4'h0, exp}, "readback");
   endtask : chk_reg

   // One 16-bit frame, MSB first; read data sampled just before each of the last eight rises
   task xfer(input logic rd, input logic [6:0] a, input logic [7:0] d, output logic [7:0] q);
      logic [15:0] f;
      f = {rd, a, d};
      scs_n = 1'b0;
      cyc(10);
      for (int i = 15; i >= 0; i--) begin
         sclk = 1'b0;
         sdi = f[i];
         cyc(10);
         if (i < 8) q[i] = sdo;
         sclk = 1'b1;
         cyc(10);
      end
      sclk = 1'b0;
      cyc(10);
      scs_n = 1'b1;
      cyc(20);
   endtask : xfer

   task wr(input logic [6:0] a, input logic [7:0] d);
      logic [7:0] q;
      xfer(1'b0, a, d, q);
   endtask : wr

   task rd_chk(input logic [6:0] a, input logic [7:0] exp);
      logic [7:0] q;
      xfer(1'b1, a, 8'hff, q);
      chk_reg(q, exp);
   endtask : rd_chk

   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_reset;
      for (int b = 0; b < 4; b++) begin
         rd_chk(ADDR_BRIDGE1_LIMIT + 7'(b), 8'h0a);
         chk_out(dly_cyc[b], 12'h15e, "delay cycles");
         chk_out(12'(max_ma[b]), 12'h040, "max mA");
      end
      rd_chk(ADDR_BRIDGE1_PRE, 8'hf6);
      chk_out(chr_cyc, 12'h0af, "pre charge cycles");
      chk_out(dchr_cyc, 12'h0af, "pre discharge cycles");
      chk_out({chr_ma, dchr_ma}, 12'h210, "initial mA");
   endtask : t_reset

   task t_max;
      logic [5:0] d;
      for (int c = 0; c < 4; c++) begin
         d = 6'(c * 21);
         wr(ADDR_BRIDGE1_LIMIT + 7'(c), {2'(c), d});
         rd_chk(ADDR_BRIDGE1_LIMIT + 7'(c), {2'(c), d});
         chk_out(12'(max_sel[c]), 12'(c), "max select");
         chk_out(12'(dly[c]), 12'(d), "delay target");
         chk_out(12'(max_ma[c]), 12'(64 >> c), "max mA");
         chk_out(dly_cyc[c], 12'(35 * d), "delay cycles");
      end
   endtask : t_max

   task t_pre;
      wr(ADDR_BRIDGE1_LIMIT, 8'h08);
      for (int r = 0; r < 4; r++) begin
         wr(ADDR_BRIDGE1_PRE, {2'(r), 2'(3 - r), 2'(r), 2'(3 - r)});
         chk_out(12'({chr_r, dchr_r, chr_i, dchr_i}),
                 12'({2'(r), 2'(3 - r), 2'(r), 2'(3 - r)}), "bridge 1 fields");
         chk_out(chr_cyc, 12'(35 * (r + 1)), "pre charge cycles");
         chk_out(dchr_cyc, 12'(35 * (4 - r)), "pre discharge cycles");
         chk_out(12'(chr_ma), 12'(4 << r), "initial charge mA");
         chk_out(12'(dchr_ma), 12'(4 << (3 - r)), "initial discharge mA");
      end
      rd_chk(ADDR_BRIDGE1_PRE, 8'hcc);
   endtask : t_pre

   // Unlisted offsets are only read, never written
   task t_reserved;
      rd_chk(7'h30, 8'h00);
      rd_chk(7'h2a, 8'h00);
      rd_chk(ADDR_BRIDGE1_PRE, 8'hcc);
   endtask : t_reserved

   task t_rst_mid;
      rst = 1'b1;
      cyc(4);
      rst = 1'b0;
      cyc(4);
      rd_chk(ADDR_BRIDGE4_LIMIT, 8'h0a);
      rd_chk(ADDR_BRIDGE1_PRE, 8'hf6);
   endtask : t_rst_mid

   task finish_test;
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : finish_test

   initial begin
      rst = 1'b1;
      scs_n = 1'b1;
      sclk = 1'b0;
      sdi = 1'b0;
      cyc(20);
      rst = 1'b0;
      cyc(8);
      t_reset();
      t_max();
      t_pre();
      t_reserved();
      t_rst_mid();
      finish_test();
   end

   initial begin
      repeat (40000) @(posedge clk_sys);
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      finish_test();
   end
endmodule : tb_gdr_config_bank
